// ==== logic/mlt_table.sv ====
// address learning table: lookup, learning, aging, static set, get-next
// assumes all inputs are synchronous to core_clk; one request per ready
`include "mlt_defs.svh"
module mlt_table #(
   parameter int unsigned SEC_CYC = `MLT_SEC_CYC,
   parameter int          NP      = `MLT_NPORT,
   parameter int          DEPTH   = `MLT_DEPTH,
   parameter int          SN      = `MLT_STATIC_N
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   input  wire logic                 frm_valid,
   input  wire mlt_pkg::mlt_frame_t  frm,
   input  wire mlt_pkg::mlt_lmode_t  learn_mode [NP],
   input  wire logic [NP-1:0]        own_en,
   input  wire mlt_pkg::mlt_lmode_t  own_mode [NP],
   input  wire logic                 aging_en,
   input  wire logic                 age_wr,
   input  wire logic [23:0]          age_sec,
   input  wire logic                 cfg_valid,
   input  wire mlt_pkg::mlt_cfg_t    cfg,
   input  wire logic                 commit,
   input  wire logic                 gn_valid,
   input  wire mlt_pkg::mlt_key_t    gn_key,
   output      logic                 ready,
   output      logic                 res_valid,
   output      mlt_pkg::mlt_res_t    res,
   output      logic                 cfg_done,
   output      logic                 cfg_full,
   output      logic                 gn_done,
   output      logic                 gn_end,
   output      mlt_pkg::mlt_entry_t  gn_entry,
   output      logic [23:0]          age_time
);
   import mlt_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW-1:0] SBASE = AW'(SN);

   // whether a valid entry holds the given key
   function automatic logic hit(mlt_entry_t e, mlt_key_t k);
      hit = e.valid && (e.key == k);
   endfunction

   function automatic logic [23:0] clamp(logic [23:0] s);
      if (s < `MLT_AGE_MIN)
         clamp = `MLT_AGE_MIN;
      else if (s > `MLT_AGE_MAX)
         clamp = `MLT_AGE_MAX;
      else
         clamp = s;
   endfunction

   mlt_state_t  st_r, st_nxt;
   mlt_op_t     op_r, op_nxt;
   logic [AW-1:0] addr_r, addr_nxt, rda_r, rda_nxt, wa;
   logic        iss_r, iss_nxt, rdv_r, rdv_nxt, we, age_take, go;
   mlt_scan_t   sc_r, sc_nxt;
   mlt_frame_t  fq_r, fq_nxt;
   mlt_cfg_t    cq_r, cq_nxt;
   mlt_key_t    gk_r, gk_nxt;
   mlt_lmode_t  md_r, md_nxt;
   logic        aon_r, aon_nxt, rdy_r, rdy_nxt;
   logic        rv_r, rv_nxt, cd_r, cd_nxt, cf_r, cf_nxt;
   logic        gd_r, gd_nxt, ge_r, ge_nxt;
   mlt_res_t    res_r, res_nxt;
   mlt_entry_t  gent_r, gent_nxt, e, wd;
   logic [NP-1:0] ing;
   logic [31:0] cyc_r, cyc_nxt, now_r, now_nxt;
   logic        pend_r, pend_nxt;
   logic [23:0] age_r, age_nxt;
   logic [AW*0+$bits(mlt_entry_t)-1:0] rbits;

   mlt_mem #(
      .WIDTH ($bits(mlt_entry_t)),
      .DEPTH (DEPTH)
   ) u_mem (
      .core_clk (core_clk),
      .we       (we),
      .waddr    (wa),
      .wdata    (wd),
      .raddr    (addr_r),
      .rdata    (rbits)
   );
   assign e = rbits;
   assign ing = NP'(1) << fq_r.port;

   // seconds timer, age setting and pending sweep request
   always_comb
   begin
      cyc_nxt = cyc_r + 32'h1;
      now_nxt = now_r;
      if (cyc_r == 32'(SEC_CYC - 1))
      begin
         cyc_nxt = 32'h0;
         now_nxt = now_r + 32'h1;
      end
      // a new tick beats the clear taken by the sweep
      pend_nxt = (pend_r && !age_take)
         || ((cyc_r == 32'(SEC_CYC - 1)) && aging_en);   // [RULE7]
      age_nxt = age_wr ? clamp(age_sec) : age_r;          // [RULE6]
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cyc_r  <= 32'h0;
         now_r  <= 32'h0;
         pend_r <= 1'b0;
         age_r  <= `MLT_AGE_DEF;                          // [RULE5]
      end
      else
      begin
         cyc_r  <= cyc_nxt;
         now_r  <= now_nxt;
         pend_r <= pend_nxt;
         age_r  <= age_nxt;
      end
   end

   // request intake, table scan and finishing step
   always_comb
   begin
      st_nxt = st_r;  op_nxt = op_r;  addr_nxt = addr_r;
      iss_nxt = iss_r;  sc_nxt = sc_r;  fq_nxt = fq_r;
      cq_nxt = cq_r;  gk_nxt = gk_r;  md_nxt = md_r;
      aon_nxt = aon_r;  res_nxt = res_r;  cf_nxt = cf_r;
      gent_nxt = gent_r;  ge_nxt = ge_r;
      rv_nxt = 1'b0;  cd_nxt = 1'b0;  gd_nxt = 1'b0;
      we = 1'b0;  wa = rda_r;  wd = e;
      age_take = 1'b0;  go = 1'b0;
      rdv_nxt = (st_r == ST_SCAN) && !iss_r;
      rda_nxt = addr_r;
      case (st_r)
         ST_IDLE:
         begin
            go = 1'b1;
            if (rdy_r && commit)
               op_nxt = OP_COMMIT;
            else if (rdy_r && cfg_valid)
            begin
               op_nxt = OP_CFG;
               cq_nxt = cfg;
            end
            else if (rdy_r && gn_valid)
            begin
               op_nxt = OP_GN;
               gk_nxt = gn_key;
            end
            else if (rdy_r && frm_valid)
            begin
               op_nxt = OP_FRM;
               fq_nxt = frm;
               // an owning function overrides the management mode
               md_nxt = own_en[frm.port] ? own_mode[frm.port]
                                         : learn_mode[frm.port]; // [RULE10]
            end
            else if (pend_r)
            begin
               op_nxt = OP_AGE;
               age_take = 1'b1;
               aon_nxt = aging_en;                        // [RULE7]
            end
            else
               go = 1'b0;
            if (go)
            begin
               st_nxt = ST_SCAN;
               addr_nxt = '0;
               iss_nxt = 1'b0;
               sc_nxt = '0;
            end
         end
         ST_SCAN:
         begin
            if (!iss_r)
            begin
               addr_nxt = addr_r + AW'(1);
               iss_nxt = (addr_r == LAST);                // [RULE12]
            end
            if (rdv_r)
            begin
               case (op_r)
                  OP_INIT:
                  begin
                     we = 1'b1;
                     wd = '0;
                  end
                  OP_AGE:
                     if (e.valid && !e.stat && aon_r
                         && (now_r - e.stamp >= 32'(age_r)))
                     begin
                        we = 1'b1;                        // [RULE4]
                        wd.valid = 1'b0;
                     end
                  OP_COMMIT:
                     if (e.valid && e.stat && e.del)
                     begin
                        we = 1'b1;                        // [RULE15]
                        wd.valid = 1'b0;
                     end
                  OP_CFG:
                  begin
                     if (hit(e, cq_r.key) && e.stat)
                     begin
                        sc_nxt.sfound = 1'b1;
                        sc_nxt.sidx = 13'(rda_r);
                     end
                     else if (hit(e, cq_r.key))
                     begin
                        we = 1'b1;     // learned copy yields to static
                        wd.valid = 1'b0;
                     end
                     if (!e.valid && rda_r < SBASE && !sc_r.ffound)
                     begin
                        sc_nxt.ffound = 1'b1;             // [RULE11]
                        sc_nxt.fidx = 13'(rda_r);
                     end
                  end
                  OP_FRM:
                  begin
                     if (hit(e, {fq_r.vid, fq_r.destination_address}))
                     begin
                        sc_nxt.dfound = 1'b1;             // [RULE1]
                        sc_nxt.dports = e.ports;
                     end
                     if (hit(e, {fq_r.vid, fq_r.source_address}))
                     begin
                        sc_nxt.sfound = 1'b1;
                        sc_nxt.sstat = e.stat;            // [RULE2]
                        sc_nxt.sidx = 13'(rda_r);
                     end
                     if (!e.valid && rda_r >= SBASE && !sc_r.ffound)
                     begin
                        sc_nxt.ffound = 1'b1;
                        sc_nxt.fidx = 13'(rda_r);
                     end
                  end
                  OP_GN:
                     // keep the least key not below the start key
                     if (e.valid && e.key >= gk_r
                         && (!sc_r.bfound || e.key < sc_r.best.key))
                     begin
                        sc_nxt.bfound = 1'b1;             // [RULE16]
                        sc_nxt.best = e;                  // [RULE13]
                     end
                  default:
                     we = 1'b0;
               endcase
               if (rda_r == LAST)
                  st_nxt = ST_DONE;
            end
         end
         ST_DONE:
         begin
            st_nxt = ST_IDLE;
            wd = '0;
            case (op_r)
               OP_CFG:
               begin
                  wd = {1'b1, 1'b1, cq_r.del, now_r, cq_r.key,
                        cq_r.ports};                      // [RULE14]
                  we = sc_r.sfound || sc_r.ffound;
                  wa = AW'(sc_r.sfound ? sc_r.sidx : sc_r.fidx);
                  cf_nxt = !we;
                  cd_nxt = 1'b1;
               end
               OP_GN:
               begin
                  gd_nxt = 1'b1;
                  ge_nxt = !sc_r.bfound;                  // [RULE17]
                  gent_nxt = sc_r.bfound ? sc_r.best : '0;
               end
               OP_FRM:
               begin
                  rv_nxt = 1'b1;
                  res_nxt.known = sc_r.dfound;
                  res_nxt.drop = (md_r == MLT_SECURE)
                     && !(sc_r.sfound && sc_r.sstat);     // [RULE9]
                  res_nxt.ports = res_nxt.drop ? '0
                     : sc_r.dfound ? sc_r.dports : ~ing;  // [RULE14]
                  wd = {1'b1, 1'b0, 1'b0, now_r,
                        fq_r.vid, fq_r.source_address, ing};
                  // static sources are never rewritten
                  we = (md_r == MLT_AUTO) && !sc_r.sstat
                     && (sc_r.sfound || sc_r.ffound);     // [RULE8] [RULE18]
                  wa = AW'(sc_r.sfound ? sc_r.sidx : sc_r.fidx); // [RULE3]
               end
               default:
                  we = 1'b0;
            endcase
         end
         default:
            st_nxt = ST_IDLE;
      endcase
      rdy_nxt = (st_nxt == ST_IDLE);
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= ST_SCAN;  op_r <= OP_INIT;  addr_r <= '0;
         iss_r <= 1'b0;  rdv_r <= 1'b0;  rda_r <= '0;
         sc_r <= '0;  fq_r <= '0;  cq_r <= '0;  gk_r <= '0;
         md_r <= MLT_OFF;  aon_r <= 1'b0;  rdy_r <= 1'b0;
         rv_r <= 1'b0;  res_r <= '0;  cd_r <= 1'b0;  cf_r <= 1'b0;
         gd_r <= 1'b0;  ge_r <= 1'b0;  gent_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;  op_r <= op_nxt;  addr_r <= addr_nxt;
         iss_r <= iss_nxt;  rdv_r <= rdv_nxt;  rda_r <= rda_nxt;
         sc_r <= sc_nxt;  fq_r <= fq_nxt;  cq_r <= cq_nxt;
         gk_r <= gk_nxt;  md_r <= md_nxt;  aon_r <= aon_nxt;
         rdy_r <= rdy_nxt;  rv_r <= rv_nxt;  res_r <= res_nxt;
         cd_r <= cd_nxt;  cf_r <= cf_nxt;  gd_r <= gd_nxt;
         ge_r <= ge_nxt;  gent_r <= gent_nxt;
      end
   end

   // outputs straight from registers
   assign ready    = rdy_r;
   assign res_valid = rv_r;
   assign res      = res_r;
   assign cfg_done = cd_r;
   assign cfg_full = cf_r;
   assign gn_done  = gd_r;
   assign gn_end   = ge_r;
   assign gn_entry = gent_r;
   assign age_time = age_r;

   // checks on the finished design
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_cfg_take;
      rdy_r && !commit && cfg_valid;
   endsequence
   sequence s_busy2;
      !rdy_r ##1 !rdy_r;
   endsequence

   a_cfg_busy: assert property (s_cfg_take |=> s_busy2)  // [RULE14]
      else $error("ready stayed high after a static write was taken");
   a_drop_empty: assert property ( // [RULE9]
      rv_r && res_r.drop |-> res_r.ports == '0)
      else $error("dropped frame still has egress ports");
   a_age_gated: assert property ( // [RULE7]
      we && op_r == OP_AGE |-> aon_r && !e.stat)
      else $error("aging removed an entry while off or static");
   a_learn_dyn: assert property ( // [RULE18]
      we && op_r == OP_FRM |-> wa >= SBASE && !wd.stat)
      else $error("learning wrote into the static part");
   a_cfg_slot: assert property (we && op_r == OP_CFG && wd.stat // [RULE11]
                                |-> wa < SBASE)
      else $error("static entry placed outside static part");
   a_commit_del: assert property (we && op_r == OP_COMMIT // [RULE15]
                                  |-> e.del && e.stat && !wd.valid)
      else $error("commit removed an unmarked entry");
   a_gn_order: assert property ( // [RULE16]
      gd_r && !ge_r |-> gent_r.key >= gk_r)
      else $error("get-next returned a key below the start");
   a_gn_end: assert property (gd_r && ge_r |-> gent_r == '0) // [RULE17]
      else $error("end of table came with an entry");
   a_age_range: assert property (age_r >= `MLT_AGE_MIN // [RULE6]
                                 && age_r <= `MLT_AGE_MAX)
      else $error("age time outside its range");
   // ready comes back with the answer pulse, which lasts one cycle
   a_res_pulse: assert property ($rose(rv_r) |-> rdy_r ##1 !rv_r) // [RULE1]
      else $error("frame answer not a single pulse");
endmodule // mlt_table

// ==== logic/mlt_defs.svh ====
// constants of the address learning table: sizes, codes, timing
// assumes one 200 MHz clock; included by the package and the top module
//
// Contract
// RULE1: egress ports come from destination address match
// RULE2: entries are marked static or dynamic
// RULE3: source address creates or refreshes dynamic entry
// RULE4: idle dynamic entries removed after age time
// RULE5: age time is 300 seconds after reset
// RULE6: age time clamped to 10..10000000 seconds
// RULE7: aging off means no inactivity removal
// RULE8: auto mode learns at once, disabled never
// RULE9: secure mode passes static sources, drops rest
// RULE10: owning function overrides management learning mode
// RULE11: static part holds 64 entries
// RULE12: table holds 8192 entries in total
// RULE13: readout order is VLAN then address ascending
// RULE14: static entry forwards only to its bitmap
// RULE15: marked static entries removed only at commit
// RULE16: get-next returns exact or next higher key
// RULE17: get-next past end reports end of table
// RULE18: learning never touches a static entry
`ifndef MLT_DEFS_SVH
`define MLT_DEFS_SVH
`define MLT_NPORT     8
`define MLT_DEPTH     8192
`define MLT_STATIC_N  64
`define MLT_AGE_DEF   24'd300
`define MLT_AGE_MIN   24'd10
`define MLT_AGE_MAX   24'd10000000
`define MLT_CLK_MHZ   200
`define MLT_TICK_S    1
`define MLT_SEC_CYC   (`MLT_TICK_S * `MLT_CLK_MHZ * 1000000)
`define MLT_LM_AUTO   2'h0
`define MLT_LM_OFF    2'h1
`define MLT_LM_SECURE 2'h2
`endif

// ==== logic/mlt_pkg.sv ====
// types of the address learning table
// assumes mlt_defs.svh is on the include path
package mlt_pkg;
`include "mlt_defs.svh"
   typedef enum logic [1:0]
   {
      MLT_AUTO   = `MLT_LM_AUTO,
      MLT_OFF    = `MLT_LM_OFF,
      MLT_SECURE = `MLT_LM_SECURE
   } mlt_lmode_t;

   typedef struct packed {
      logic [11:0] vid;
      logic [47:0] mac;
   } mlt_key_t;

   typedef struct packed {
      logic                    valid;
      logic                    stat;
      logic                    del;
      logic [31:0]             stamp;
      mlt_key_t                key;
      logic [`MLT_NPORT-1:0]   ports;
   } mlt_entry_t;

   typedef struct packed {
      logic [11:0]             vid;
      logic [47:0]             destination_address;
      logic [47:0]             source_address;
      logic [2:0]              port;
   } mlt_frame_t;

   typedef struct packed {
      mlt_key_t                key;
      logic [`MLT_NPORT-1:0]   ports;
      logic                    del;
   } mlt_cfg_t;

   typedef struct packed {
      logic [`MLT_NPORT-1:0]   ports;
      logic                    drop;
      logic                    known;
   } mlt_res_t;

   typedef struct packed {
      logic                    dfound;
      logic [`MLT_NPORT-1:0]   dports;
      logic                    sfound;
      logic                    sstat;
      logic [12:0]             sidx;
      logic                    ffound;
      logic [12:0]             fidx;
      logic                    bfound;
      mlt_entry_t              best;
   } mlt_scan_t;

   typedef enum logic [2:0]
   {
      OP_INIT, OP_AGE, OP_COMMIT, OP_CFG, OP_GN, OP_FRM
   } mlt_op_t;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h1,
      ST_SCAN = 3'h2,
      ST_DONE = 3'h4
   } mlt_state_t;
endpackage

// ==== logic/mlt_mem.sv ====
// single write, single read table memory with registered read data
// assumes writes and reads share core_clk
module mlt_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8192,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             core_clk,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output      logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   // storage write and read data register
   always_ff @(posedge core_clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // mlt_mem

// ==== tb/mlt_far_end.sv ====
// far side model: port datapath frames and management requests
// assumes the table samples on rising core_clk; drives on falling edges
module mlt_far_end (
   input  wire logic                core_clk,
   input  wire logic                ready,
   input  wire logic                res_valid,
   input  wire logic                cfg_done,
   input  wire logic                gn_done,
   output      logic                frm_valid,
   output      mlt_pkg::mlt_frame_t frm,
   output      logic                cfg_valid,
   output      mlt_pkg::mlt_cfg_t   cfg,
   output      logic                commit,
   output      logic                gn_valid,
   output      mlt_pkg::mlt_key_t   gn_key,
   output      int                  timeouts
);
   timeunit 1ns;
   timeprecision 100ps;
   import mlt_pkg::*;

   // request lines idle at time zero
   initial
   begin
      {frm_valid, cfg_valid, commit, gn_valid} = 4'h0;
      frm = '0;
      cfg = '0;
      gn_key = '0;
      timeouts = 0;
   end

   // wait at a falling edge until the table is ready for a request
   task automatic to_ready();
      int n;
      n = 0;
      @(negedge core_clk);
      while (ready !== 1'b1 && n < 4000)
      begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 4000)
         timeouts++;
   endtask

   // wait for an answer pulse: 0 frame, 1 static write, 2 get-next
   task automatic to_answer(input int sel);
      logic a;
      int   n;
      n = 0;
      a = 1'b0;
      while (a !== 1'b1 && n < 4000)
      begin
         @(negedge core_clk);
         a = (sel == 0) ? res_valid : (sel == 1) ? cfg_done : gn_done;
         n++;
      end
      if (n >= 4000)
         timeouts++;
   endtask

   // one frame; released fields are scrambled, never left stale
   task automatic send_frame(input logic [2:0] p, input logic [11:0] v,
                             input logic [47:0] da, input logic [47:0] sa);
      to_ready();
      frm = {v, da, sa, p};
      frm_valid = 1'b1;
      @(negedge core_clk);
      frm_valid = 1'b0;
      frm = ~frm;
      to_answer(0);
   endtask

   // static entry: key, member bitmap and delete mark from management
   task automatic send_cfg(input logic [11:0] v, input logic [47:0] m,
                           input logic [7:0] pm, input logic del);
      to_ready();
      cfg = {v, m, pm, del};
      cfg_valid = 1'b1;
      @(negedge core_clk);
      cfg_valid = 1'b0;
      cfg = ~cfg;
      to_answer(1);
   endtask

   // save request: no answer pulse, wait for the scan to end
   task automatic send_commit();
      to_ready();
      commit = 1'b1;
      @(negedge core_clk);
      commit = 1'b0;
      to_ready();
   endtask

   // get-next request from a start key
   task automatic send_gn(input logic [11:0] v, input logic [47:0] m);
      to_ready();
      gn_key = {v, m};
      gn_valid = 1'b1;
      @(negedge core_clk);
      gn_valid = 1'b0;
      gn_key = ~gn_key;
      to_answer(2);
   endtask
endmodule // mlt_far_end

// ==== tb/tb.sv ====
// testbench of the address learning table with the far side model
// assumes a shrunk table (128 entries, 8 static) and 400-cycle seconds
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import mlt_pkg::*;

   localparam int          SEC = 400;
   localparam logic [47:0] A_MAC = 48'h0000000000a1;
   localparam logic [47:0] C_MAC = 48'h0000000000c3;
   localparam logic [47:0] E_MAC = 48'h000000000005;
   localparam logic [47:0] X_MAC = 48'h0000000000b2;
   logic        core_clk, rst_b, frm_valid, cfg_valid, commit, gn_valid;
   logic        aging_en, age_wr, ready, res_valid, cfg_done, cfg_full;
   logic        gn_done, gn_end;
   logic [7:0]  own_en;
   logic [23:0] age_sec, age_time;
   mlt_frame_t  frm;
   mlt_cfg_t    cfg;
   mlt_key_t    gn_key;
   mlt_res_t    res;
   mlt_entry_t  gn_entry;
   mlt_lmode_t  learn_mode [8];
   mlt_lmode_t  own_mode [8];
   int          errors, checks_done, tmo;

   mlt_table #(.SEC_CYC(SEC), .DEPTH(128), .SN(8)) i_mlt_table (
      .core_clk(core_clk), .rst_b(rst_b), .frm_valid(frm_valid),
      .frm(frm), .learn_mode(learn_mode), .own_en(own_en),
      .own_mode(own_mode), .aging_en(aging_en), .age_wr(age_wr),
      .age_sec(age_sec), .cfg_valid(cfg_valid), .cfg(cfg),
      .commit(commit), .gn_valid(gn_valid), .gn_key(gn_key),
      .ready(ready), .res_valid(res_valid), .res(res),
      .cfg_done(cfg_done), .cfg_full(cfg_full), .gn_done(gn_done),
      .gn_end(gn_end), .gn_entry(gn_entry), .age_time(age_time));

   mlt_far_end i_mlt_far_end (
      .core_clk(core_clk), .ready(ready), .res_valid(res_valid),
      .cfg_done(cfg_done), .gn_done(gn_done), .frm_valid(frm_valid),
      .frm(frm), .cfg_valid(cfg_valid), .cfg(cfg), .commit(commit),
      .gn_valid(gn_valid), .gn_key(gn_key), .timeouts(tmo));

   // 200 MHz clock
   initial
      core_clk = 1'b0;
   always #2.5 core_clk = ~core_clk;

   // verdict and end of run
   task automatic end_of_test();
      errors += tmo;
      if (errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // compare a plain value
   task automatic chk_val(input string w, input logic [23:0] e, s);
      checks_done++;
      if (s !== e)
      begin
         errors++;
         $display("unexpected %s: expected %h seen %h", w, e, s);
      end
   endtask

   // compare a forwarding answer
   task automatic chk_res(input string w, input mlt_res_t e);
      checks_done++;
      if (res !== e)
      begin
         errors++;
         $display("unexpected %s: expected %h seen %h", w, e, res);
      end
   endtask

   // get-next from a start key and compare end flag and entry
   task automatic gn_chk(input logic [11:0] sv, input logic [47:0] sm,
                         input logic ee, input logic [11:0] v,
                         input logic [47:0] m, input logic st,
                         input logic [7:0] pm);
      logic [69:0] e, s;
      i_mlt_far_end.send_gn(sv, sm);
      e = {ee, v, m, st, pm};
      s = {gn_end, gn_entry.key, gn_entry.stat, gn_entry.ports};
      checks_done++;
      if (s !== e)
      begin
         errors++;
         $display("unexpected get-next: expected %h seen %h", e, s);
      end
   endtask

   // destination lookup from port 3, which never learns
   task automatic look(input logic [11:0] v, input logic [47:0] da,
                       input logic [7:0] pm, input logic kn);
      i_mlt_far_end.send_frame(3'h3, v, da, 48'h000000000077);
      chk_res("lookup", {pm, 1'b0, kn});
   endtask

   // pulse a new age time in
   task automatic set_age(input logic [23:0] s);
      @(negedge core_clk);
      age_sec = s;
      age_wr = 1'b1;
      @(negedge core_clk);
      age_wr = 1'b0;
   endtask

   // reset value and clamping of the age time
   task automatic t_age();
      chk_val("age_time", 24'h00012c, age_time);
      set_age(24'h000003);
      chk_val("age_time", 24'h00000a, age_time);
      set_age(24'hffffff);
      chk_val("age_time", 24'h989680, age_time);
      set_age(24'h00012c);
      chk_val("age_time", 24'h00012c, age_time);
   endtask

   // learning on an automatic port, none on a disabled one
   task automatic t_learn();
      i_mlt_far_end.send_frame(3'h2, 12'h001, X_MAC, A_MAC);
      chk_res("flood", {8'hfb, 1'b0, 1'b0});
      look(12'h001, A_MAC, 8'h04, 1'b1);
      look(12'h001, X_MAC, 8'hf7, 1'b0);
      look(12'h001, 48'h000000000077, 8'hf7, 1'b0);
   endtask

   // static entry forwarding, untouched by learning
   task automatic t_static();
      i_mlt_far_end.send_cfg(12'h002, C_MAC, 8'h30, 1'b0);
      chk_val("cfg_full", 24'h0, 24'(cfg_full));
      look(12'h002, C_MAC, 8'h30, 1'b1);
      i_mlt_far_end.send_frame(3'h1, 12'h002, A_MAC, C_MAC);
      look(12'h002, C_MAC, 8'h30, 1'b1);
   endtask

   // secure port passes static sources only; owner overrides mode
   task automatic t_secure();
      learn_mode[4] = MLT_SECURE;
      i_mlt_far_end.send_frame(3'h4, 12'h002, A_MAC, C_MAC);
      chk_res("secure pass", {8'hef, 1'b0, 1'b0});
      i_mlt_far_end.send_frame(3'h4, 12'h002, C_MAC, X_MAC);
      chk_val("drop", 24'h1, 24'(res.drop));
      chk_val("drop ports", 24'h0, 24'(res.ports));
      look(12'h002, X_MAC, 8'hf7, 1'b0);
      own_mode[4] = MLT_AUTO;
      own_en[4] = 1'b1;
      i_mlt_far_end.send_frame(3'h4, 12'h002, C_MAC, E_MAC);
      look(12'h002, E_MAC, 8'h10, 1'b1);
   endtask

   // ordered get-next walk and end of table
   task automatic t_gn();
      gn_chk(12'h0, 48'h0, 1'b0, 12'h1, A_MAC, 1'b0, 8'h04);
      gn_chk(12'h2, 48'h0, 1'b0, 12'h2, E_MAC, 1'b0, 8'h10);
      gn_chk(12'h2, 48'h6, 1'b0, 12'h2, C_MAC, 1'b1, 8'h30);
      gn_chk(12'h2, C_MAC, 1'b0, 12'h2, C_MAC, 1'b1, 8'h30);
      gn_chk(12'h2, 48'hc4, 1'b1, 12'h0, 48'h0, 1'b0, 8'h00);
   endtask

   // deletion waits for commit, then static capacity
   task automatic t_del_full();
      i_mlt_far_end.send_cfg(12'h002, C_MAC, 8'h30, 1'b1);
      look(12'h002, C_MAC, 8'h30, 1'b1);
      i_mlt_far_end.send_commit();
      look(12'h002, C_MAC, 8'hf7, 1'b0);
      for (int i = 1; i <= 9; i++)
      begin
         i_mlt_far_end.send_cfg(12'h003, 48'(i), 8'h01, 1'b0);
         chk_val("cfg_full", 24'(i > 8), 24'(cfg_full));
      end
      look(12'h003, 48'h8, 8'h01, 1'b1);
      look(12'h003, 48'h9, 8'hf7, 1'b0);
   endtask

   // no removal while aging is off, removal once it is on
   task automatic t_aging();
      aging_en = 1'b0;
      set_age(24'h00000a);
      i_mlt_far_end.send_frame(3'h6, 12'h005, A_MAC, X_MAC);
      repeat (13 * SEC) @(negedge core_clk);
      look(12'h005, X_MAC, 8'h40, 1'b1);
      aging_en = 1'b1;
      repeat (3 * SEC) @(negedge core_clk);
      look(12'h005, X_MAC, 8'hf7, 1'b0);
   endtask

   // main sequence
   initial
   begin
      {rst_b, age_wr, aging_en} = 3'h1;
      age_sec = 24'h0;
      own_en = 8'h00;
      errors = 0;
      checks_done = 0;
      foreach (learn_mode[i])
      begin
         learn_mode[i] = MLT_AUTO;
         own_mode[i] = MLT_OFF;
      end
      learn_mode[3] = MLT_OFF;
      repeat (2) @(negedge core_clk);
      rst_b = 1'b1;
      t_age();
      t_learn();
      t_static();
      t_secure();
      t_gn();
      t_del_full();
      t_aging();
      end_of_test();
   end

   // watchdog well beyond the expected run
   initial
   begin
      #300000;
      errors++;
      end_of_test();
   end
endmodule // tb
